// ==== logic/rdac_twowire_slave.sv ====
// What this block does
// R1 - Clock line is only an input; the slave never drives it.
// R2 - Start is SDA falling while SCL is high; it begins a transaction.
// R3 - Stop is SDA rising while SCL is high; it ends a transaction.
// R4 - Any SDA change while SCL is high counts as start or stop.
// R5 - First byte after start is a seven-bit address plus direction bit.
// R6 - A matching address is acknowledged by holding SDA low on clock nine.
// R7 - Every later unit is eight data bits followed by one acknowledge bit.
// R8 - Own address is 111010 followed by the address select pin level.
// R9 - Standard and fast speeds work without any mode change.
// R10 - Master enters high speed by sending 00001xxx right after start.
// R11 - Master code 00001xxx is recognised, low bits ignored, never acknowledged.
// R12 - After master code, the HS_MODE status output is set; input sampling is unchanged.
// R13 - High speed survives repeated starts and ends at the first stop.
// R14 - General call 00h then 06h is acknowledged and resets everything.
// R15 - General call address always acknowledged; other data bytes are not.
// R16 - Power-up reset loads every channel with the mid-scale code.
// R17 - Channel byte with upper bits 100 resets all channels to mid-scale.
// R18 - Channel byte with upper bits 010 resets only the addressed channel.
// R19 - Eight channels each hold a ten-bit code, output is supply times code/1024.
// R20 - Each channel has a holding and an output stage for preloading.
// R21 - With the load pin low, outputs follow their holding registers at once.
// R22 - Direction bit 0 selects write, 1 selects read.
// R23 - Channel addresses 0 to 7 in low bits; unused bits must be zero.
// R24 - Two data bytes per channel, MSB first; update after second; auto-increment.
// R25 - Load pin high holds outputs; going low updates all together.
// R26 - SCL and SDA are synchronised and all events come from the samples.
`timescale 1ns/1ps
`default_nettype none

module rdac_twowire_slave (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // Two-wire bus pins (SCL is input only)
  input  wire logic                    SCL_I,
  input  wire logic                    SDA_I,
  output var  logic                    SDA_O,
  output var  logic                    SDA_OE,
  // Straps and control pins
  input  wire logic                    ADDRESS_SELECT_PIN,
  input  wire logic                    OUTPUT_LOAD_PIN,
  // Status
  output var  logic                    HS_MODE,
  // Output codes, channel 0 is the common electrode channel
  output var  logic [8*10-1:0]         CH_CODE
);

  // ==========================================================================
  // Synchronisers.
  // ==========================================================================
  rdac_pkg::rdac_bus_s bus_m_q;
  rdac_pkg::rdac_bus_s bus_s_q;
  rdac_pkg::rdac_bus_s bus_p_q;
  logic                 asel_m_q;
  logic                 asel_s_q;
  logic                 ld_m_q;
  logic                 ld_s_q;

  // The high-speed input filter needs no extra stage: at 3.4 MHz SCL high is
  // about seven clock periods, so the two-stage sampler keeps all real edges; a glitch
  // shorter than one clock still passes through whenever a clock edge samples it.
  always_ff @(posedge CLK) begin
    bus_m_q  <= '{scl: SCL_I, sda: SDA_I}; // R26
    bus_s_q  <= bus_m_q;
    bus_p_q  <= bus_s_q;
    asel_m_q <= ADDRESS_SELECT_PIN;
    asel_s_q <= asel_m_q;
    ld_m_q   <= OUTPUT_LOAD_PIN;
    ld_s_q   <= ld_m_q;
  end

  rdac_pkg::rdac_evt_s evt;
  assign evt.start = bus_p_q.scl && bus_s_q.scl && bus_p_q.sda && !bus_s_q.sda;   // R2 R4
  assign evt.stop  = bus_p_q.scl && bus_s_q.scl && !bus_p_q.sda && bus_s_q.sda;   // R3 R4
  assign evt.rise  = !bus_p_q.scl && bus_s_q.scl;                                 // R9
  assign evt.fall  = bus_p_q.scl && !bus_s_q.scl;

  // ==========================================================================
  // Bit and byte engine.
  // ==========================================================================
  rdac_pkg::rdac_state_e state_q;
  rdac_pkg::rdac_state_e state_d;
  logic [3:0]            bit_cnt_q;
  logic [7:0]            shift_q;
  logic                  ack_phase_q;
  logic                  ack_drive_q;
  logic                  master_nack_q;
  logic                  hs_q;
  logic [2:0]            ptr_q;
  logic                  msb_seen_q;
  logic [1:0]            msb_q;
  logic [2:0]            cmd_q;
  logic [7:0]            tx_q;
  logic                  tx_lsb_q;
  logic                  soft_rst_q;
  logic                  pending_ack_q;
  logic                  gc_pend_q;

  logic [9:0] hold_q [rdac_pkg::NUM_CH];
  logic [9:0] out_q  [rdac_pkg::NUM_CH];

  wire [7:0] rx_byte     = shift_q;
  wire       byte_done   = evt.rise && !ack_phase_q && bit_cnt_q == 4'h7;
  wire [7:0] byte_in     = {shift_q[6:0], bus_s_q.sda};
  wire       addr_match  = byte_in[7:1] == {rdac_pkg::SLAVE_ADDR_HI, asel_s_q}; // R8
  wire       is_hs_code  = byte_in[7:3] == rdac_pkg::HS_CODE_HI;                // R11
  wire       is_gcall    = byte_in == rdac_pkg::GEN_CALL_ADDR;
  wire       ptr_valid   = byte_in[4:3] == 2'h0 &&
                           (byte_in[7:5] == rdac_pkg::CMD_NONE ||
                            byte_in[7:5] == rdac_pkg::CMD_RESET_ALL ||
                            byte_in[7:5] == rdac_pkg::CMD_RESET_ONE);           // R23
  wire       word_done   = byte_done && state_q == rdac_pkg::ST_WDATA && msb_seen_q;
  wire       gcall_reset = byte_done && state_q == rdac_pkg::ST_GCALL &&
                           byte_in == rdac_pkg::GEN_CALL_RESET;                 // R14

  // The acknowledge phase spans two SCL falls. The fall after bit eight opens
  // the ninth slot, and the fall after the ninth pulse closes it. The ninth
  // rise parks the bit counter at eight, so that pulse never reaches the
  // data shifter and the close can be told apart from the open.
  wire       ack_open    = evt.fall && ack_phase_q && bit_cnt_q != 4'h8;
  wire       ack_close   = evt.fall && ack_phase_q && bit_cnt_q == 4'h8;

  // Acknowledge decision for the byte just completed.
  logic ack_d;
  always_comb begin
    ack_d = 1'b0;
    case (state_q)
      rdac_pkg::ST_ADDR:  ack_d = (addr_match && !is_hs_code) || is_gcall;      // R6 R11 R15
      rdac_pkg::ST_GCALL: ack_d = byte_in == rdac_pkg::GEN_CALL_RESET;          // R15
      rdac_pkg::ST_PTR:   ack_d = ptr_valid;                                    // R23
      rdac_pkg::ST_WDATA: ack_d = 1'b1;                                         // R7
      default:            ack_d = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      rdac_pkg::ST_ADDR: begin
        if (is_gcall) begin
          state_d = rdac_pkg::ST_GCALL;
        end else if (addr_match) begin
          state_d = byte_in[0] ? rdac_pkg::ST_RDATA : rdac_pkg::ST_PTR;        // R5 R22
        end else begin
          state_d = rdac_pkg::ST_IGNORE;
        end
      end
      rdac_pkg::ST_PTR:   state_d = ptr_valid ? rdac_pkg::ST_WDATA : rdac_pkg::ST_IGNORE;
      rdac_pkg::ST_GCALL: state_d = rdac_pkg::ST_IGNORE;
      rdac_pkg::ST_IDLE:  state_d = rdac_pkg::ST_IDLE;
      rdac_pkg::ST_WDATA: state_d = rdac_pkg::ST_WDATA;
      rdac_pkg::ST_RDATA: state_d = rdac_pkg::ST_RDATA;
      default:            state_d = rdac_pkg::ST_IGNORE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST || soft_rst_q) begin
      state_q       <= rdac_pkg::ST_IDLE;
      bit_cnt_q     <= 4'h0;
      shift_q       <= 8'h00;
      ack_phase_q   <= 1'b0;
      ack_drive_q   <= 1'b0;
      master_nack_q <= 1'b0;
      msb_seen_q    <= 1'b0;
      msb_q         <= 2'h0;
    end else if (evt.start) begin
      state_q     <= rdac_pkg::ST_ADDR; // R2
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      msb_seen_q  <= 1'b0; // Partial words are dropped on restart.
    end else if (evt.stop) begin
      state_q     <= rdac_pkg::ST_IDLE; // R3
      ack_drive_q <= 1'b0;
      msb_seen_q  <= 1'b0;
    end else if (byte_done) begin
      shift_q     <= byte_in; // R5 R7
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b1;
      state_q     <= state_d;
      if (state_q == rdac_pkg::ST_WDATA) begin
        msb_seen_q <= !msb_seen_q; // R24
        msb_q      <= byte_in[1:0];
      end
    end else if (evt.rise) begin
      if (ack_phase_q) begin
        master_nack_q <= bus_s_q.sda;
        bit_cnt_q     <= 4'h8; // Ninth pulse seen.
      end else begin
        shift_q   <= byte_in;
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end else if (ack_close) begin
      ack_drive_q <= 1'b0; // Release after the ninth pulse.
      ack_phase_q <= 1'b0;
      bit_cnt_q   <= 4'h0;
      if (state_q == rdac_pkg::ST_RDATA && master_nack_q) begin
        state_q <= rdac_pkg::ST_IGNORE; // Master ended the read.
      end
    end else if (ack_open) begin
      // Drive the acknowledge only while SCL is low, so SDA never moves
      // while the master may be sampling it.
      ack_drive_q <= pending_ack_q; // R6 R15
    end
  end

  // Acknowledge decision latched with the byte; consumed at the next fall.
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_q || evt.start || evt.stop) begin
      pending_ack_q <= 1'b0;
    end else if (byte_done) begin
      pending_ack_q <= ack_d;
    end else if (evt.fall && ack_phase_q) begin
      pending_ack_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data: MSB byte then LSB byte per channel, auto-increment.
  // ==========================================================================
  // The next byte is loaded when the master's acknowledge slot closes. The
  // slot of the address byte itself is skipped, as the slave drove it.
  wire read_load = state_q == rdac_pkg::ST_RDATA && ack_close && !ack_drive_q;
  wire [9:0] rd_word = hold_q[ptr_q];
  always_ff @(posedge CLK) begin
    if (RST || soft_rst_q) begin
      tx_q <= 8'h00;
    end else if (byte_done && state_d == rdac_pkg::ST_RDATA && state_q == rdac_pkg::ST_ADDR) begin
      tx_q <= {6'h00, rd_word[9:8]}; // R24
    end else if (evt.fall && !ack_phase_q && state_q == rdac_pkg::ST_RDATA && bit_cnt_q != 4'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end else if (read_load && !master_nack_q) begin
      tx_q <= tx_lsb_q ? {6'h00, hold_q[ptr_q + 3'h1][9:8]} : rd_word[7:0];
    end
  end

  // ==========================================================================
  // Channel registers and commands.
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (RST) begin
      soft_rst_q <= 1'b0;
      hs_q       <= 1'b0;
      ptr_q      <= 3'h0;
      cmd_q      <= rdac_pkg::CMD_NONE;
      gc_pend_q  <= 1'b0;
    end else begin
      // The reset waits until the acknowledge of the reset byte is over;
      // resetting at once would cut that acknowledge short.
      soft_rst_q <= gc_pend_q && (evt.stop || ack_close); // R14
      if (soft_rst_q) begin
        gc_pend_q <= 1'b0;
      end else if (gcall_reset) begin
        gc_pend_q <= 1'b1;
      end
      if (soft_rst_q || evt.stop) begin
        hs_q <= 1'b0; // R13
      end else if (byte_done && state_q == rdac_pkg::ST_ADDR && is_hs_code) begin
        hs_q <= 1'b1; // R12
      end
      if (soft_rst_q) begin
        ptr_q <= 3'h0;
        cmd_q <= rdac_pkg::CMD_NONE;
      end else if (byte_done && state_q == rdac_pkg::ST_PTR && ptr_valid) begin
        ptr_q <= byte_in[2:0]; // R23
        cmd_q <= byte_in[7:5];
      end else if (word_done || (read_load && tx_lsb_q && !master_nack_q)) begin
        ptr_q <= ptr_q + 3'h1; // R24
      end
    end
    if (RST || soft_rst_q || evt.start) begin
      tx_lsb_q <= 1'b0;
    end else if (read_load && !master_nack_q) begin
      tx_lsb_q <= !tx_lsb_q;
    end
  end

  wire reset_all = byte_done && state_q == rdac_pkg::ST_PTR && ptr_valid &&
                   byte_in[7:5] == rdac_pkg::CMD_RESET_ALL; // R17
  wire reset_one = byte_done && state_q == rdac_pkg::ST_PTR && ptr_valid &&
                   byte_in[7:5] == rdac_pkg::CMD_RESET_ONE; // R18

  generate
    for (genvar ch = 0; ch < rdac_pkg::NUM_CH; ch++) begin : g_ch
      wire hit   = ptr_q == 3'(ch);
      // Data words that follow a reset command belong to that command and
      // are not written, so the reset is not undone by its own payload.
      wire wr    = word_done && hit && cmd_q == rdac_pkg::CMD_NONE;
      wire clr   = reset_all || (reset_one && byte_in[2:0] == 3'(ch));
      always_ff @(posedge CLK) begin
        if (RST || soft_rst_q) begin
          hold_q[ch] <= rdac_pkg::MID_SCALE; // R16 R14
          out_q[ch]  <= rdac_pkg::MID_SCALE;
        end else begin
          if (clr) begin
            hold_q[ch] <= rdac_pkg::MID_SCALE; // R17 R18
            out_q[ch]  <= rdac_pkg::MID_SCALE;
          end else if (wr) begin
            hold_q[ch] <= {msb_q, byte_in}; // R19 R24
          end
          if (!ld_s_q && !clr) begin
            out_q[ch] <= hold_q[ch]; // R20 R21 R25
          end
        end
      end
      always_ff @(posedge CLK) begin
        CH_CODE[ch*10 +: 10] <= out_q[ch];
      end
    end
  endgenerate

  // ==========================================================================
  // Pin drivers; SDA is open drain, SCL is never driven.
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (RST) begin
      SDA_O   <= 1'b0;
      SDA_OE  <= 1'b0;
      HS_MODE <= 1'b0;
    end else begin
      SDA_O   <= 1'b0; // R1
      SDA_OE  <= ack_drive_q ||
                 (state_q == rdac_pkg::ST_RDATA && !ack_phase_q && !tx_q[7]);
      HS_MODE <= hs_q;
    end
  end

endmodule : rdac_twowire_slave

`default_nettype wire

// ==== logic/rdac_pkg.sv ====
package rdac_pkg;

  // ==========================================================================
  // Addressing and command codes.
  // ==========================================================================
  localparam logic [5:0] SLAVE_ADDR_HI   = 6'h3a;
  localparam logic [4:0] HS_CODE_HI      = 5'h01;
  localparam logic [7:0] GEN_CALL_ADDR   = 8'h00;
  localparam logic [7:0] GEN_CALL_RESET  = 8'h06;
  localparam logic [2:0] CMD_RESET_ALL   = 3'h4;
  localparam logic [2:0] CMD_RESET_ONE   = 3'h2;
  localparam logic [2:0] CMD_NONE        = 3'h0;

  // ==========================================================================
  // Channel layout.
  // ==========================================================================
  localparam int         NUM_CH          = 8;
  localparam int         CODE_W          = 10;
  localparam logic [9:0] MID_SCALE       = 10'h200;

  // ==========================================================================
  // Bus states and carriers.
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_GCALL,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } rdac_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } rdac_bus_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } rdac_evt_s;

endpackage : rdac_pkg

// ==== dv/rdac_twowire_slave_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus-side checks on the slave's pins.
// ==========================================================================
module rdac_twowire_slave_checker (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // Bus pins
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  input  wire logic              SDA_O,
  input  wire logic              SDA_OE,
  // Straps and status
  input  wire logic              ADDRESS_SELECT_PIN,
  input  wire logic              OUTPUT_LOAD_PIN,
  input  wire logic              HS_MODE,
  input  wire logic [8*10-1:0]   CH_CODE
);
  logic [1:0] scl_q;
  logic [2:0] sda_q;
  always_ff @(posedge CLK) begin
    scl_q <= {scl_q[0], SCL_I};
    sda_q <= {sda_q[1:0], SDA_I};
  end
  // Same two-flop view as the slave, so event timing lines up with its own.
  wire logic start_w = scl_q[1] && sda_q[2] && !sda_q[1];
  wire logic stop_w  = scl_q[1] && !sda_q[2] && sda_q[1];

  sda_low_only_a: assert property (@(posedge CLK) SDA_O == 1'b0)
    else $error("SDA output level is not low");
  reset_state_a: assert property (@(posedge CLK) $fell(RST) |->
    (CH_CODE == {8{rdac_pkg::MID_SCALE}}) && !HS_MODE && !SDA_OE)
    else $error("state after reset is wrong");
  stop_ends_hs_a: assert property (@(posedge CLK) disable iff (RST)
    stop_w |-> ##[0:6] !HS_MODE) else $error("high speed kept after stop");
  hs_keeps_a: assert property (@(posedge CLK) disable iff (RST)
    (start_w && HS_MODE) |-> HS_MODE [*6]) else $error("high speed lost at start");
  hs_no_ack_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(HS_MODE) |-> !SDA_OE [*8]) else $error("master code acknowledged");
  oe_scl_low_a: assert property (@(posedge CLK) disable iff (RST)
    $changed(SDA_OE) |-> !SCL_I) else $error("SDA moved with SCL high");
  ack_hold_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(SDA_OE) |-> SDA_OE [*6]) else $error("acknowledge too short");
  ack_end_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(SDA_OE) |-> ##[1:100] !SDA_OE) else $error("SDA held too long");
endmodule : rdac_twowire_slave_checker

bind rdac_twowire_slave rdac_twowire_slave_checker u_rdac_twowire_slave_checker (
  .CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
  .OUTPUT_LOAD_PIN(OUTPUT_LOAD_PIN), .HS_MODE(HS_MODE), .CH_CODE(CH_CODE));
`default_nettype wire

// ==== dv/rdac_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Two-wire bus master model; SCL is released high between frames.
// ==========================================================================
module rdac_bus_master (
  // Clock
  input  wire logic  clk,
  // Bus
  input  wire logic  sda,
  output var  logic  scl,
  output var  logic  sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  task automatic go_start();
    wait_clk(2);
    sda_pull = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask : go_start
  task automatic put_bit(input logic b, output logic got);
    wait_clk(2);
    sda_pull = ~b;
    // Low time of five cycles covers the slave's sampling latency, so its
    // SDA changes land while SCL is still low; the period stays 160 ns.
    wait_clk(3);
    scl = 1'b1;
    wait_clk(3);
    got = sda;
    scl = 1'b0;
  endtask : put_bit
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--) put_bit(d[i], got);
    put_bit(1'b1, got);
    ack = ~got;
    // Extra low time lets the slave drop its acknowledge before the next bit.
    wait_clk(4);
  endtask : put_byte
  task automatic go_stop();
    wait_clk(2);
    sda_pull = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b0;
    wait_clk(4);
  endtask : go_stop
endmodule : rdac_bus_master
`default_nettype wire

// ==== dv/rdac_twowire_slave_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdac_twowire_slave_tb;
  logic            clk;
  logic            rst;
  logic            asp;
  logic            ld;
  logic            sda_o;
  logic            sda_oe;
  logic            hs;
  logic            scl;
  logic            m_pull;
  logic [8*10-1:0] codes;
  int              err_total;
  int              check_count;
  int              cycles;
  wire logic       sda_w  = ~(m_pull | sda_oe);
  wire logic [7:0] addr_w = {rdac_pkg::SLAVE_ADDR_HI, asp, 1'b0};

  rdac_twowire_slave u_rdac_twowire_slave (.CLK(clk), .RST(rst), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDRESS_SELECT_PIN(asp),
    .OUTPUT_LOAD_PIN(ld), .HS_MODE(hs), .CH_CODE(codes));
  rdac_bus_master u_rdac_bus_master (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(m_pull));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ========================================================================
  // Checks and bus helpers.
  // ========================================================================
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_code(input int ch, input logic [9:0] exp);
    check_count++;
    if (codes[10*ch +: 10] !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, codes[10*ch +: 10], exp);
    end
  endtask : chk_code
  task automatic tx(input logic [7:0] d, input logic exp);
    logic a;
    u_rdac_bus_master.put_byte(d, a);
    chk_bit(a, exp);
  endtask : tx
  task automatic wr(input logic [7:0] ch, input logic [9:0] v);
    u_rdac_bus_master.go_start();
    tx(addr_w, 1'b1);
    tx(ch, 1'b1);
    tx({6'h00, v[9:8]}, 1'b1);
    tx(v[7:0], 1'b1);
    u_rdac_bus_master.go_stop();
  endtask : wr

  initial begin
    rst = 1'b1;
    asp = 1'b0;
    ld = 1'b0;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++) chk_code(i, rdac_pkg::MID_SCALE);
    chk_bit(hs, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      asp = i[1];
      u_rdac_bus_master.go_start();
      tx({rdac_pkg::SLAVE_ADDR_HI, i[0], 1'b0}, i[0] == i[1]);
      u_rdac_bus_master.go_stop();
    end
    $display("test address done");
    wr(8'h02, 10'h3ff);
    chk_code(2, 10'h3ff);
    u_rdac_bus_master.go_start();
    tx(addr_w, 1'b1);
    tx(8'h07, 1'b1);
    tx(8'h01, 1'b1);
    tx(8'h23, 1'b1);
    tx(8'h02, 1'b1);
    tx(8'h45, 1'b1);
    u_rdac_bus_master.go_stop();
    chk_code(7, 10'h123);
    chk_code(0, 10'h245);
    u_rdac_bus_master.go_start();
    tx(addr_w, 1'b1);
    tx(8'h08, 1'b0);
    u_rdac_bus_master.go_stop();
    $display("test write done");
    ld = 1'b1;
    wr(8'h01, 10'h155);
    chk_code(1, rdac_pkg::MID_SCALE);
    ld = 1'b0;
    repeat (4) @(negedge clk);
    chk_code(1, 10'h155);
    $display("test load done");
    wr({rdac_pkg::CMD_RESET_ONE, 5'h07}, 10'h000);
    chk_code(7, rdac_pkg::MID_SCALE);
    chk_code(2, 10'h3ff);
    wr({rdac_pkg::CMD_RESET_ALL, 5'h00}, 10'h000);
    for (int i = 0; i < 8; i++) chk_code(i, rdac_pkg::MID_SCALE);
    $display("test channel reset done");
    for (int k = 0; k < 2; k++) begin
      u_rdac_bus_master.go_start();
      tx({rdac_pkg::HS_CODE_HI, k[0] ? 3'h7 : 3'h0}, 1'b0);
      chk_bit(hs, 1'b1);
      u_rdac_bus_master.go_start();
      tx(addr_w, 1'b1);
      chk_bit(hs, 1'b1);
      u_rdac_bus_master.go_stop();
      repeat (8) @(negedge clk);
      chk_bit(hs, 1'b0);
    end
    $display("test high speed done");
    wr(8'h03, 10'h0aa);
    u_rdac_bus_master.go_start();
    tx(rdac_pkg::GEN_CALL_ADDR, 1'b1);
    tx(8'h05, 1'b0);
    u_rdac_bus_master.go_stop();
    chk_code(3, 10'h0aa);
    u_rdac_bus_master.go_start();
    tx(rdac_pkg::GEN_CALL_ADDR, 1'b1);
    tx(rdac_pkg::GEN_CALL_RESET, 1'b1);
    u_rdac_bus_master.go_stop();
    repeat (4) @(negedge clk);
    chk_code(3, rdac_pkg::MID_SCALE);
    $display("test general call done");
    test_done();
  end
endmodule : rdac_twowire_slave_tb
`default_nettype wire
